/* File: host_nv_memory_access_ports.sv */
// Host register ports for serial EEPROM commands and direct expansion ROM byte access
`timescale 1ns/1ps

module host_nv_memory_access_ports
#(
    parameter int ROM_ADDR_W = 16
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host register access
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic [3:0] regByteEn,
    output logic [31:0] regRdata,
    output logic regReady,
    // Serial EEPROM pins
    output logic eeSelect,
    output logic eeClock,
    output logic eeDataOut,
    input wire logic eeDataIn,
    // Expansion ROM byte bus
    output logic [ROM_ADDR_W-1:0] romAddr,
    output logic romReadStrobe,
    output logic romWriteStrobe,
    output logic [7:0] romWdata,
    input wire logic [7:0] romRdata,
    input wire logic romAck
);
    import nv_access_pkg::*;

    typedef enum logic [1:0] {
        R_IDLE,
        R_READ,
        R_WRITE
    } rom_state_e;

    logic [15:0] nv_word_buffer;
    logic [7:0] nv_word_index;
    logic [1:0] nv_cmd_code;
    logic nv_cmd_pending;
    logic [15:0] option_rom_byte_pointer;
    rom_state_e romState;
    logic engStart;
    logic engDone;
    logic [15:0] engReadWord;
    logic engSelect;
    logic engClock;
    logic engDataOut;
    logic [7:0] next_romByte;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire hitBuffer = (regAddr == OFS_WORD_BUFFER);
    wire hitCommand = (regAddr == OFS_COMMAND);
    wire hitPointer = (regAddr == OFS_ROM_POINTER);
    wire hitPort = (regAddr == OFS_ROM_PORT);
    wire lowLanes = regByteEn[0] && regByteEn[1];
    // Buffer locked while a command runs so a read result cannot be overwritten mid-flight
    wire bufferWrite = regWrite && hitBuffer && lowLanes && !nv_cmd_pending;
    wire commandWrite = regWrite && hitCommand && lowLanes && !nv_cmd_pending;
    wire pointerWrite = regWrite && hitPointer && lowLanes && romState == R_IDLE;
    // Ready still high means the held request has just been served, not a new one
    wire portFree = (romState == R_IDLE) && !regReady;
    wire portWrite = regWrite && hitPort && regByteEn[0] && portFree;
    wire portRead = regRead && hitPort && portFree;
    wire [1:0] subCode = regWdata[IDX_MSB:SUB_LSB];
    wire [1:0] newCode = regWdata[CODE_MSB:CODE_LSB];
    wire isGlobal = (newCode == CODE_GLOBAL);
    wire cmdHasData = (newCode == CODE_WRITE) || (isGlobal && subCode == SUB_FILL);
    wire cmdHasRead = (newCode == CODE_READ);
    wire cmdWaits = (newCode == CODE_WRITE) || (newCode == CODE_ERASE) ||
                    (isGlobal && (subCode == SUB_FILL || subCode == SUB_CLEAR));
    wire [15:0] commandView = {nv_cmd_pending, 5'h00, nv_cmd_code, nv_word_index};
    wire [31:0] readMux = hitBuffer ? {16'h0000, nv_word_buffer} :
                          hitCommand ? {16'h0000, commandView} :
                          hitPointer ? {16'h0000, option_rom_byte_pointer} : 32'h0000_0000;
    wire romBusy = (romState != R_IDLE);
    wire portAccessEnd = romBusy && romAck;
    // A port write without lane 0 carries no byte; answer it at once so the host is not stalled
    wire portLaneOff = regWrite && hitPort && !regByteEn[0] && !regRead && !regReady;
    wire plainAnswer = ((regRead || regWrite) && !hitPort) || portLaneOff;

    assign engStart = commandWrite;
    assign next_romByte = (romState == R_READ && romAck) ? romRdata : 8'h00;

    // ----------------------------------------
    // Command and buffer registers
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv_word_index <= RST_WORD_INDEX;
            nv_cmd_code <= RST_CMD_CODE;
            nv_cmd_pending <= 1'b0;
        end
        else if (commandWrite)
        begin
            nv_word_index <= regWdata[IDX_MSB:IDX_LSB];
            nv_cmd_code <= newCode;
            nv_cmd_pending <= 1'b1;
        end
        else if (engDone)
            nv_cmd_pending <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            nv_word_buffer <= RST_WORD_BUFFER;
        else if (engDone && nv_cmd_code == CODE_READ)
            nv_word_buffer <= engReadWord;
        else if (bufferWrite)
            nv_word_buffer <= regWdata[15:0];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            option_rom_byte_pointer <= RST_ROM_POINTER;
        else if (pointerWrite)
            option_rom_byte_pointer <= regWdata[15:0];
    end

    // ----------------------------------------
    // Expansion ROM byte port
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            romState <= R_IDLE;
            romAddr <= '0;
            romReadStrobe <= 1'b0;
            romWriteStrobe <= 1'b0;
            romWdata <= 8'h00;
        end
        else
        begin
            unique case (romState)
                R_IDLE:
                    if (portRead || portWrite)
                    begin
                        romAddr <= ROM_ADDR_W'(option_rom_byte_pointer);
                        romReadStrobe <= portRead;
                        romWriteStrobe <= portWrite && !portRead;
                        romWdata <= regWdata[7:0];
                        romState <= portRead ? R_READ : R_WRITE;
                    end
                R_READ, R_WRITE:
                    if (romAck)
                    begin
                        romReadStrobe <= 1'b0;
                        romWriteStrobe <= 1'b0;
                        romState <= R_IDLE;
                    end
            endcase
        end
    end

    // ----------------------------------------
    // Host answer
    // ----------------------------------------
    // Port reads and lane-0 port writes stall until the ROM acknowledges; all others answer next cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdata <= 32'h0000_0000;
            regReady <= 1'b0;
        end
        else
        begin
            regReady <= plainAnswer || portAccessEnd;
            if (portAccessEnd)
                regRdata <= {24'h000000, next_romByte};
            else if (regRead && !hitPort)
                regRdata <= readMux;
            else
                regRdata <= 32'h0000_0000;
        end
    end

    nv_serial_engine #(
        .ADDR_W(8),
        .HALF_CYCLES(SK_HALF_CYCLES)
    ) u_engine (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(engStart),
        .opCode(isGlobal ? CODE_GLOBAL : newCode),
        .opAddr(regWdata[IDX_MSB:IDX_LSB]),
        .opData(nv_word_buffer),
        .hasData(cmdHasData),
        .hasRead(cmdHasRead),
        .waitReady(cmdWaits),
        .done(engDone),
        .readWord(engReadWord),
        .eeSelect(engSelect),
        .eeClock(engClock),
        .eeDataOut(engDataOut),
        .eeDataIn(eeDataIn)
    );

    assign eeSelect = engSelect;
    assign eeClock = engClock;
    assign eeDataOut = engDataOut;
endmodule

/* File: nv_access_pkg.sv */
// Package: register offsets, field positions, reset values and command codes for the NV access ports
package nv_access_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_WORD_BUFFER = 8'h48;
    localparam logic [7:0] OFS_COMMAND = 8'h4A;
    localparam logic [7:0] OFS_ROM_POINTER = 8'h4C;
    localparam logic [7:0] OFS_ROM_PORT = 8'h50;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] RST_WORD_BUFFER = 16'h0000;
    localparam logic [15:0] RST_ROM_POINTER = 16'h0000;
    localparam logic [7:0] RST_WORD_INDEX = 8'h00;
    localparam logic [1:0] RST_CMD_CODE = 2'h0;

    // ----------------------------------------
    // Command register field positions
    // ----------------------------------------
    localparam int IDX_LSB = 0;
    localparam int IDX_MSB = 7;
    localparam int SUB_LSB = 6;
    localparam int CODE_LSB = 8;
    localparam int CODE_MSB = 9;
    localparam int PENDING_BIT = 15;
    localparam int WORD_COUNT = 256;

    // ----------------------------------------
    // Serial command encodings
    // ----------------------------------------
    localparam logic [1:0] CODE_GLOBAL = 2'h0;
    localparam logic [1:0] CODE_WRITE = 2'h1;
    localparam logic [1:0] CODE_READ = 2'h2;
    localparam logic [1:0] CODE_ERASE = 2'h3;
    localparam logic [1:0] SUB_LOCK = 2'h0;
    localparam logic [1:0] SUB_FILL = 2'h1;
    localparam logic [1:0] SUB_CLEAR = 2'h2;
    localparam logic [1:0] SUB_UNLOCK = 2'h3;

    // ----------------------------------------
    // Serial EEPROM timing (cycles of mclk)
    // ----------------------------------------
    localparam int SK_HALF_CYCLES = 2;
    localparam int FRAME_BITS = 27;

    typedef enum logic [1:0] {
        OP_LOCK,
        OP_FILL,
        OP_CLEAR,
        OP_UNLOCK
    } global_op_e;

endpackage

/* File: nv_serial_engine.sv */
// Serial EEPROM shifter: one start bit, opcode, address and optional data, then an optional read and an optional wait for ready
`timescale 1ns/1ps

module nv_serial_engine
#(
    parameter int ADDR_W = 8,
    parameter int HALF_CYCLES = nv_access_pkg::SK_HALF_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Command request
    input wire logic start,
    input wire logic [1:0] opCode,
    input wire logic [ADDR_W-1:0] opAddr,
    input wire logic [15:0] opData,
    input wire logic hasData,
    input wire logic hasRead,
    input wire logic waitReady,
    // Result
    output logic done,
    output logic [15:0] readWord,
    // Serial pins
    output logic eeSelect,
    output logic eeClock,
    output logic eeDataOut,
    input wire logic eeDataIn
);
    import nv_access_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE,
        S_SHIFT,
        S_READ,
        S_GAP,
        S_BUSY,
        S_DONE
    } eng_state_e;

    localparam int SHIFT_W = 3 + ADDR_W + 16;
    // The pin path lags about five clocks behind the chip's data edge; with a short
    // half period the first read rise still sees stale data, so one more rise is
    // taken and the stale bit drops off the top of the 16-bit word
    localparam int READ_BITS = (HALF_CYCLES < 6) ? 17 : 16;

    eng_state_e state;
    logic [SHIFT_W-1:0] shiftOut;
    logic [5:0] bitsLeft;
    logic [7:0] divCount;
    logic [2:0] dinSync;
    logic dinStable;
    logic [5:0] frameLen;
    // Request qualifiers are held for the whole frame; the host bus moves on at once
    logic longFrame;
    logic wantRead;
    logic wantReady;

    // Data in is a pin: three flops, change accepted once the last two agree
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            dinSync <= 3'h0;
        else
            dinSync <= {dinSync[1:0], eeDataIn};
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            dinStable <= 1'b0;
        else if (dinSync[1] == dinSync[2])
            dinStable <= dinSync[2];
    end

    wire halfTick = (divCount == 8'(HALF_CYCLES - 1));
    wire riseTick = halfTick && !eeClock;
    wire fallTick = halfTick && eeClock;
    assign frameLen = longFrame ? 6'(SHIFT_W) : 6'(3 + ADDR_W);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            shiftOut <= '0;
            bitsLeft <= 6'h00;
            divCount <= 8'h00;
            eeSelect <= 1'b0;
            eeClock <= 1'b0;
            eeDataOut <= 1'b0;
            readWord <= 16'h0000;
            done <= 1'b0;
            longFrame <= 1'b0;
            wantRead <= 1'b0;
            wantReady <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            divCount <= (state == S_IDLE || halfTick) ? 8'h00 : divCount + 8'h01;
            // Serial clock stands still outside shifting, busy polling included
            if ((state == S_SHIFT || state == S_READ) && halfTick)
                eeClock <= !eeClock;
            unique case (state)
                S_IDLE:
                begin
                    eeClock <= 1'b0;
                    if (start)
                    begin
                        shiftOut <= {1'b1, opCode, opAddr, opData};
                        bitsLeft <= hasData ? 6'(SHIFT_W) : 6'(3 + ADDR_W);
                        longFrame <= hasData;
                        wantRead <= hasRead;
                        wantReady <= waitReady;
                        eeSelect <= 1'b1;
                        state <= S_SHIFT;
                    end
                end
                S_SHIFT:
                    if (fallTick || (bitsLeft == frameLen && riseTick == 1'b0 && eeClock == 1'b0 && divCount == 8'h00))
                    begin
                        eeDataOut <= shiftOut[SHIFT_W-1];
                        shiftOut <= {shiftOut[SHIFT_W-2:0], 1'b0};
                        if (bitsLeft == 6'h00)
                        begin
                            bitsLeft <= 6'(READ_BITS);
                            state <= wantRead ? S_READ : S_GAP;
                        end
                        else
                            bitsLeft <= bitsLeft - 6'h01;
                    end
                S_READ:
                    if (riseTick)
                    begin
                        readWord <= {readWord[14:0], dinStable};
                        bitsLeft <= bitsLeft - 6'h01;
                        if (bitsLeft == 6'h01)
                            state <= S_GAP;
                    end
                S_GAP:
                    if (halfTick)
                    begin
                        eeSelect <= 1'b0;
                        eeClock <= 1'b0;
                        eeDataOut <= 1'b0;
                        state <= wantReady ? S_BUSY : S_DONE;
                    end
                S_BUSY:
                begin
                    // Chip drives data low until its internal programming ends
                    eeSelect <= 1'b1;
                    if (halfTick && dinStable)
                        state <= S_DONE;
                end
                S_DONE:
                begin
                    eeSelect <= 1'b0;
                    eeClock <= 1'b0;
                    done <= 1'b1;
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: host_nv_memory_access_ports_chk.sv */
// Checker: register-port and ROM-port timing of the NV access block
`timescale 1ns/1ps
module host_nv_memory_access_ports_chk
#(
    parameter int ROM_ADDR_W = 16
)
(
    // Clock, reset and register bus
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    input wire logic regReady,
    // Serial and ROM side
    input wire logic eeSelect,
    input wire logic [ROM_ADDR_W-1:0] romAddr,
    input wire logic romReadStrobe,
    input wire logic romWriteStrobe,
    input wire logic [7:0] romWdata,
    input wire logic [7:0] romRdata,
    input wire logic romAck
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Ready still high means the last port access is just closing, not a new one
    wire romIdle = !romReadStrobe && !romWriteStrobe && !regReady;
    chk_ready_reg: assert property ((regWrite || regRead) && regAddr != 8'h50 |=> regReady)
        else $error("register access not answered");
    chk_ptr_upper: assert property (regRead && regAddr == 8'h4C |=> regRdata[31:16] == 16'h0000)
        else $error("pointer upper half not zero");
    chk_pending_shown: assert property (regWrite && regAddr == 8'h4A && !eeSelect ##[2:4]
        regRead && regAddr == 8'h4A |=> regRdata[15]) else $error("pending flag low after launch");
    chk_frame_start: assert property (regWrite && regAddr == 8'h4A && !eeSelect |-> ##[1:8] eeSelect)
        else $error("serial frame not started");
    chk_rom_hold: assert property (romReadStrobe && !romAck |=> romReadStrobe && $stable(romAddr))
        else $error("ROM read dropped or moved early");
    chk_port_read: assert property (regRead && regAddr == 8'h50 && romIdle |=> romReadStrobe)
        else $error("port read did not strobe ROM");
    chk_port_write: assert property (regWrite && regAddr == 8'h50 && romIdle |=>
        romWriteStrobe && romWdata == regWdata[7:0]) else $error("port write data wrong");
    chk_port_answer: assert property ((romReadStrobe || romWriteStrobe) && romAck |=>
        regReady && !romReadStrobe && !romWriteStrobe) else $error("ROM access not closed");
    chk_read_byte: assert property (romReadStrobe && romAck |=> regRdata[7:0] == $past(romRdata))
        else $error("ROM byte not returned");
endmodule

bind host_nv_memory_access_ports host_nv_memory_access_ports_chk #(.ROM_ADDR_W(ROM_ADDR_W)) chk_i (
    .mclk(mclk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regReady(regReady), .eeSelect(eeSelect), .romAddr(romAddr),
    .romReadStrobe(romReadStrobe), .romWriteStrobe(romWriteStrobe), .romWdata(romWdata),
    .romRdata(romRdata), .romAck(romAck));

/* File: nv_memory_model.sv */
// Partner model: serial EEPROM word store and expansion ROM byte store
`timescale 1ns/1ps
module nv_memory_model
(
    // Core clock
    input wire logic mclk,
    // Serial EEPROM pins
    input wire logic eeSelect,
    input wire logic eeClock,
    input wire logic eeDataOut,
    output logic eeDataIn,
    // Expansion ROM byte bus
    input wire logic [15:0] romAddr,
    input wire logic romReadStrobe,
    input wire logic romWriteStrobe,
    input wire logic [7:0] romWdata,
    output logic [7:0] romRdata,
    output logic romAck,
    input wire logic [3:0] romWait
);
    logic [15:0] words [256];
    logic [7:0] rom [65536];
    logic [26:0] sr = '0;
    logic [26:0] w;
    logic [15:0] outWord = '0;
    logic [3:0] rc = '0;
    logic pc = 0;
    logic rd = 0;
    logic dout = 0;
    logic locked = 1;
    int n = 0;
    int busy = 0;
    task automatic put(input logic [7:0] a, input logic [15:0] v, input logic all);
        for (int i = 0; i < 256; i++)
            if (all || i == int'(a))
                words[i] <= v;
        busy <= 20;
    endtask
    initial
    begin
        romAck = 0;
        for (int i = 0; i < 65536; i++)
            rom[i] = i[7:0] ^ 8'h3C;
    end
    assign w = {sr[25:0], eeDataOut};
    // Ready/busy shows whether selected or not; the idle level is the pull-up
    assign eeDataIn = busy != 0 ? 1'b0 : (rd ? dout : 1'b1);
    // Outside an acknowledge the data lines carry no valid byte
    assign romRdata = romAck ? rom[romAddr] : ~rom[romAddr];
    always @(posedge mclk)
    begin
        pc <= eeClock;
        if (busy != 0)
            busy <= busy - 1;
        if (!eeSelect)
        begin
            n <= 0;
            rd <= 0;
        end
        else if (eeClock && !pc && (n != 0 || eeDataOut))
        begin
            n <= n + 1;
            sr <= w;
            if (n == 10 && w[9:8] == 2'h2)
            begin
                outWord <= words[w[7:0]];
                rd <= 1;
            end
            if (n == 10 && !locked && w[9:8] == 2'h3) put(w[7:0], 16'hFFFF, 0);
            if (n == 10 && !locked && w[9:6] == 4'h2) put(8'h00, 16'hFFFF, 1);
            if (n == 10 && w[9:6] == 4'h0) locked <= 1;
            if (n == 10 && w[9:6] == 4'h3) locked <= 0;
            if (n == 26 && !locked && w[25:24] == 2'h1) put(w[23:16], w[15:0], 0);
            if (n == 26 && !locked && w[25:22] == 4'h1) put(8'h00, w[15:0], 1);
        end
        else if (!eeClock && pc && rd)
        begin
            dout <= outWord[15];
            outWord <= outWord << 1;
        end
    end
    always @(posedge mclk)
    begin
        if (romAck)
        begin
            romAck <= 0;
            rc <= '0;
        end
        else if ((romReadStrobe || romWriteStrobe) && rc == romWait)
        begin
            romAck <= 1;
            if (romWriteStrobe)
                rom[romAddr] <= romWdata;
        end
        else if (romReadStrobe || romWriteStrobe)
            rc <= rc + 4'h1;
    end
endmodule

/* File: tb_host_nv_memory_access_ports.sv */
// Testbench: NV access ports against the memory partner model
`timescale 1ns/1ps
module tb_host_nv_memory_access_ports;
    import nv_access_pkg::*;
    typedef struct {logic [15:0] wd; logic [1:0] code; logic [7:0] idx; logic [15:0] exp;} row_s;
    logic mclk = 0;
    logic rst_n = 0;
    logic regWrite = 0;
    logic regRead = 0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic [3:0] romWait = 4'h0;
    logic [31:0] regRdata, q;
    logic [15:0] romAddr;
    logic [7:0] romWdata, romRdata;
    logic regReady, eeSelect, eeClock, eeDataOut, eeDataIn, romReadStrobe, romWriteStrobe, romAck;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    row_s rows[14] = '{'{16'h0000, CODE_GLOBAL, 8'hC0, 16'h0000}, '{16'h1234, CODE_WRITE, 8'h05, 16'h1234},
        '{16'hBEEF, CODE_WRITE, 8'hFF, 16'hBEEF}, '{16'h0000, CODE_READ, 8'h05, 16'h1234},
        '{16'h0000, CODE_READ, 8'hFF, 16'hBEEF}, '{16'h0000, CODE_ERASE, 8'h05, 16'h0000},
        '{16'h0000, CODE_READ, 8'h05, 16'hFFFF}, '{16'h5A5A, CODE_GLOBAL, 8'h40, 16'h5A5A},
        '{16'h0000, CODE_READ, 8'h80, 16'h5A5A}, '{16'h0000, CODE_GLOBAL, 8'h80, 16'h0000},
        '{16'h0000, CODE_READ, 8'h80, 16'hFFFF}, '{16'h0000, CODE_GLOBAL, 8'h00, 16'h0000},
        '{16'h1111, CODE_WRITE, 8'h07, 16'h1111}, '{16'h0000, CODE_READ, 8'h07, 16'hFFFF}};
    always #50 mclk = ~mclk;
    host_nv_memory_access_ports host_nv_memory_access_ports_i (.mclk(mclk), .rst_n(rst_n),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regByteEn(4'hF),
        .regRdata(regRdata), .regReady(regReady), .eeSelect(eeSelect), .eeClock(eeClock),
        .eeDataOut(eeDataOut), .eeDataIn(eeDataIn), .romAddr(romAddr), .romReadStrobe(romReadStrobe),
        .romWriteStrobe(romWriteStrobe), .romWdata(romWdata), .romRdata(romRdata), .romAck(romAck));
    nv_memory_model nv_memory_model_i (.mclk(mclk), .eeSelect(eeSelect), .eeClock(eeClock),
        .eeDataOut(eeDataOut), .eeDataIn(eeDataIn), .romAddr(romAddr), .romReadStrobe(romReadStrobe),
        .romWriteStrobe(romWriteStrobe), .romWdata(romWdata), .romRdata(romRdata), .romAck(romAck),
        .romWait(romWait));
    task print_verdict;
        if (n_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // Register ports drop after one edge; the ROM port is held until ready
    task acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        regWrite <= wr;
        regRead <= !wr;
        regAddr <= a;
        regWdata <= d;
        do
        begin
            @(posedge mclk);
            n++;
            if (n == 1 && a != OFS_ROM_PORT)
            begin
                regWrite <= 0;
                regRead <= 0;
            end
        end
        while (regReady !== 1'b1 && n < 500);
        q = regRdata;
        if (a == OFS_ROM_PORT)
        begin
            regWrite <= 0;
            regRead <= 0;
        end
        cmp({31'h0, regReady}, 32'h1, "no ready");
    endtask
    task issue(input logic [1:0] c, input logic [7:0] i);
        acc(1, OFS_COMMAND, {22'h0, c, i});
        acc(0, OFS_COMMAND, 32'h0);
        cmp(q & 32'h83FF, {16'h0, 1'b1, 5'h00, c, i}, "command word");
    endtask
    task settle;
        int n;
        n = 0;
        do
        begin
            acc(0, OFS_COMMAND, 32'h0);
            n++;
        end
        while (q[15] !== 1'b0 && n < 200);
        cmp({31'h0, q[15]}, 32'h0, "pending stuck");
    endtask
    task rst_values;
        acc(0, OFS_WORD_BUFFER, 32'h0);
        cmp(q, {16'h0, RST_WORD_BUFFER}, "buffer reset");
        acc(0, OFS_ROM_POINTER, 32'h0);
        cmp(q, {16'h0, RST_ROM_POINTER}, "pointer reset");
        acc(0, OFS_COMMAND, 32'h0);
        cmp(q & 32'h83FF, 32'h0, "command reset");
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            $display("CHECK FAILED %0t timeout", $time);
            print_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        foreach (rows[k])
        begin
            acc(1, OFS_WORD_BUFFER, {16'h0, rows[k].wd});
            issue(rows[k].code, rows[k].idx);
            settle();
            acc(0, OFS_WORD_BUFFER, 32'h0);
            cmp(q, {16'h0, rows[k].exp}, "word buffer");
        end
        // Pointer first, then one port access per byte; prompt write, slow read
        acc(1, OFS_ROM_POINTER, 32'h12);
        acc(1, OFS_ROM_PORT, 32'h5C);
        acc(1, OFS_ROM_POINTER, 32'h13);
        romWait <= 4'h9;
        acc(0, OFS_ROM_PORT, 32'h0);
        cmp(q & 32'hFF, 32'h2F, "rom byte");
        acc(1, OFS_ROM_POINTER, 32'h12);
        acc(0, OFS_ROM_PORT, 32'h0);
        cmp(q & 32'hFF, 32'h5C, "rom programmed");
        acc(0, OFS_ROM_POINTER, 32'h0);
        cmp(q, 32'h12, "pointer");
        acc(0, 8'h44, 32'h0);
        cmp(q, 32'h0, "unmapped");
        // A buffer write while a command runs must not land
        acc(1, OFS_WORD_BUFFER, 32'h2222);
        issue(CODE_GLOBAL, 8'h00);
        acc(1, OFS_WORD_BUFFER, 32'h7777);
        settle();
        acc(0, OFS_WORD_BUFFER, 32'h0);
        cmp(q, 32'h2222, "buffer written while pending");
        issue(CODE_READ, 8'h10);
        rst_n <= 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        rst_values();
        print_verdict();
    end
endmodule
